// *** hw/nbl_pkg.sv ***
// constants, enumerations and timing counts of the nand block-lock host controller
// assumes a 250 MHz core clock and a flash whose pins are synchronous to it
//
// What the datasheet requires
// RULE1: feature pin high enables block lock and power-on auto read.
// RULE2: every block comes up locked after power-up.
// RULE3: command 2Ah returns all blocks to the locked state.
// RULE4: a write-protect low pulse relocks all blocks, also at power-up.
// RULE5: lock-tight blocks go back to locked only by write-protect pulse.
// RULE6: unlock is 23h, start block address, 24h, end block address.
// RULE7: only one contiguous unlocked range exists at a time.
// RULE8: start block address must not be above end block address.
// RULE9: equal start and end addresses unlock exactly one block.
// RULE10: program and erase only succeed on unlocked blocks.
// RULE11: command 2Ch turns locked blocks into lock-tight blocks.
// RULE12: commands that touch lock-tight blocks are ignored.
// RULE13: program or erase on a protected block shows busy 1 to 10 ms.
// RULE14: 7Ah plus block address, then reads return that block's lock status.
// RULE15: never issue the lock status read while the flash is busy.
// RULE16: lock status mode persists until a new command is written.
// RULE17: status bit2 unlocked, bit1 locked, bit0 lock-tight.
// RULE18: with the feature pin low, protection is read with 70h.
// RULE19: feature pin high makes the flash read page zero at power-on.
// RULE20: ready/busy drops after program, erase or read start, rises when done.
// RULE21: flash disables everything below its supply detector threshold.
// RULE22: wait at least 10 us after power-up before any command.
// RULE23: hold write-protect low during power-up and power-down.
// RULE24: block address lives in row bits A14 to A24, page bits ignored.
// RULE25: one lock state per block, checked at each program or erase.
package nbl_pkg;

  // ----------------------------------------------------------------
  // command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_LOCK = 8'h2a;
  localparam logic [7:0] CMD_LOCK_TIGHT = 8'h2c;
  localparam logic [7:0] CMD_UNLOCK_START = 8'h23;
  localparam logic [7:0] CMD_UNLOCK_END = 8'h24;
  localparam logic [7:0] CMD_LOCK_STATUS = 8'h7a;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;

  // ----------------------------------------------------------------
  // address layout: row cycle one carries A9..A16, cycle two A17..A24
  // ----------------------------------------------------------------
  localparam int BLK_W = 11;
  localparam int BLK_LO_POS = 5;
  localparam int BLK_LO_W = 3;

  // ----------------------------------------------------------------
  // lock status bits
  // ----------------------------------------------------------------
  localparam int STAT_UNLOCK_BIT = 2;
  localparam int STAT_LOCK_BIT = 1;
  localparam int STAT_TIGHT_BIT = 0;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 4000;
  localparam int STROBE_NS = 25;
  localparam int STROBE_CYC = (STROBE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int BUSY_SETTLE_NS = 100;
  localparam int BUSY_SETTLE_CYC = (BUSY_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int WP_PULSE_NS = 100;
  localparam int WP_PULSE_CYC = (WP_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int PWRUP_US = 10;
  localparam int PWRUP_CYC = (PWRUP_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CNT_W = 12;

  // ----------------------------------------------------------------
  // user operations and bus cycle kinds
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_LOCK = 3'b000,
    OP_LOCK_TIGHT = 3'b001,
    OP_UNLOCK = 3'b010,
    OP_STATUS = 3'b011,
    OP_WP_PULSE = 3'b100
  } nbl_op_e;

  typedef enum logic [1:0] {
    CYC_CMD = 2'b00,
    CYC_ADDR = 2'b01,
    CYC_READ = 2'b10
  } nbl_cyc_e;

endpackage

// *** hw/nbl_cyc_if.sv ***
// bus-cycle carrier between the operation sequencer and the pin cycle engine
// assumes one clock domain shared by both ends
`timescale 1ns/10ps
`default_nettype none

interface nbl_cyc_if;
  import nbl_pkg::*;
  logic req;
  nbl_cyc_e kind;
  logic [7:0] wdata;
  logic done;
  logic [7:0] rdata;
  logic cle;
  logic ale;
  logic we_n;
  logic re_n;
  logic io_oe;
  logic [7:0] io_out;

  modport master (output req, output kind, output wdata, input done, input rdata,
                  input cle, input ale, input we_n, input re_n, input io_oe, input io_out);
  modport engine (input req, input kind, input wdata, output done, output rdata,
                  output cle, output ale, output we_n, output re_n, output io_oe, output io_out);
endinterface

`default_nettype wire

// *** hw/nbl_cyc_engine.sv ***
// pin cycle engine: one command, address or read cycle per request
// assumes the master holds req steady until done
`timescale 1ns/10ps
`default_nettype none

module nbl_cyc_engine
  import nbl_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] io_in,
  nbl_cyc_if.engine cyc
);

  typedef enum logic [1:0] {
    E_IDLE = 2'b00,
    E_LOW = 2'b01,
    E_HIGH = 2'b10
  } nbl_est_e;

  typedef struct packed {
    nbl_est_e st;
    logic [3:0] cnt;
    logic done;
    logic [7:0] rdata;
    logic cle;
    logic ale;
    logic we_n;
    logic re_n;
    logic oe;
    logic [7:0] dout;
  } nbl_eng_s;

  nbl_eng_s s_q, s_d;

  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    case (s_q.st)
      E_IDLE: begin
        // the done cycle still shows the old step, so a new cycle waits one clock
        if (cyc.req && !s_q.done) begin
          s_d.st = E_LOW;
          s_d.cnt = 4'(STROBE_CYC - 1);
          s_d.cle = (cyc.kind == CYC_CMD);
          s_d.ale = (cyc.kind == CYC_ADDR);
          s_d.oe = (cyc.kind != CYC_READ);
          s_d.dout = cyc.wdata;
          s_d.we_n = (cyc.kind == CYC_READ);
          s_d.re_n = (cyc.kind != CYC_READ);
        end
      end
      E_LOW: begin
        if (s_q.cnt == 4'h0) begin
          // data is sampled at the end of the low phase, just before re rises
          if (!s_q.re_n) begin
            s_d.rdata = io_in;
          end
          s_d.we_n = 1'b1;
          s_d.re_n = 1'b1;
          s_d.st = E_HIGH;
          s_d.cnt = 4'(STROBE_CYC - 1);
        end else begin
          s_d.cnt = s_q.cnt - 4'h1;
        end
      end
      E_HIGH: begin
        if (s_q.cnt == 4'h0) begin
          s_d.st = E_IDLE;
          s_d.done = 1'b1;
          s_d.cle = 1'b0;
          s_d.ale = 1'b0;
          s_d.oe = 1'b0;
        end else begin
          s_d.cnt = s_q.cnt - 4'h1;
        end
      end
      default: s_d.st = E_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '{st: E_IDLE, cnt: 4'h0, done: 1'b0, rdata: 8'h00, cle: 1'b0, ale: 1'b0,
               we_n: 1'b1, re_n: 1'b1, oe: 1'b0, dout: 8'h00};
    end else begin
      s_q <= s_d;
    end
  end

  assign cyc.done = s_q.done;
  assign cyc.rdata = s_q.rdata;
  assign cyc.cle = s_q.cle;
  assign cyc.ale = s_q.ale;
  assign cyc.we_n = s_q.we_n;
  assign cyc.re_n = s_q.re_n;
  assign cyc.io_oe = s_q.oe;
  assign cyc.io_out = s_q.dout;

  a_strobe_width: assert property (@(posedge clk) disable iff (rst)
    $fell(s_q.we_n) |-> !s_q.we_n [*7] ##1 s_q.we_n)
    else $error("write strobe low phase has wrong width");
  a_one_strobe: assert property (@(posedge clk) disable iff (rst)
    !(!s_q.we_n && !s_q.re_n))
    else $error("write and read strobes low together");

endmodule // nbl_cyc_engine

`default_nettype wire

// *** hw/nbl_host.sv ***
// host controller for the flash block-lock feature: lock, lock-tight,
// range unlock, lock status read and write-protect pulse
// assumes ready/busy is pulled up outside and arrives synchronous to CORE_CLK
`timescale 1ns/10ps
`default_nettype none

module nbl_host
  import nbl_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  input wire logic FEATURE_EN,
  input wire logic REQ_VALID,
  input wire logic [2:0] REQ_OP,
  input wire logic [BLK_W-1:0] REQ_START_BLK,
  input wire logic [BLK_W-1:0] REQ_END_BLK,
  output logic REQ_READY,
  output logic REQ_ERR,
  output logic RESP_VALID,
  output logic [7:0] RESP_STATUS,
  output logic LOCK_FEATURE_ENABLE_PIN,
  output logic CE_N,
  output logic CLE,
  output logic ALE,
  output logic WE_N,
  output logic READ_STROBE_N,
  output logic WP_N,
  input wire logic READY_BUSY_N,
  input wire logic [7:0] IO_IN,
  output logic [7:0] IO_OUT,
  output logic IO_OE
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    S_PWRUP = 3'b000,
    S_IDLE = 3'b001,
    S_WAITRDY = 3'b010,
    S_SEND = 3'b011,
    S_SETTLE = 3'b100,
    S_WPLOW = 3'b101
  } nbl_st_e;

  typedef struct packed {
    nbl_st_e st;
    logic [CNT_W-1:0] cnt;
    logic [2:0] step;
    nbl_op_e op;
    logic feat;
    logic [BLK_W-1:0] start_blk;
    logic [BLK_W-1:0] end_blk;
    logic [7:0] status;
    logic resp_valid;
    logic err;
    logic wp_n;
    logic ce_n;
  } nbl_host_s;

  nbl_host_s s_q, s_d;
  nbl_cyc_if cyc ();

  nbl_cyc_engine u_engine (
    .clk(CORE_CLK),
    .rst(SYS_RST),
    .io_in(IO_IN),
    .cyc(cyc)
  );

  // ----------------------------------------------------------------
  // step decode: cycle kind, data and last flag for each operation step
  // ----------------------------------------------------------------
  nbl_cyc_e stp_kind;
  logic [7:0] stp_data;
  logic stp_last;
  logic [BLK_W-1:0] stp_blk;

  always_comb begin
    stp_kind = CYC_CMD;
    stp_data = 8'h00;
    stp_last = 1'b0;
    stp_blk = (s_q.step >= 3'h3) ? s_q.end_blk : s_q.start_blk;
    case (s_q.op)
      OP_LOCK: begin
        stp_data = CMD_LOCK; // RULE3
        stp_last = 1'b1;
      end
      OP_LOCK_TIGHT: begin
        stp_data = CMD_LOCK_TIGHT;
        stp_last = 1'b1;
      end
      OP_UNLOCK: begin
        case (s_q.step)
          3'h0: stp_data = CMD_UNLOCK_START; // RULE6
          3'h3: stp_data = CMD_UNLOCK_END; // RULE6
          default: stp_kind = CYC_ADDR;
        endcase
        stp_last = (s_q.step == 3'h5);
      end
      default: begin
        // feature pin low: plain status read carries no address
        if (s_q.step == 3'h0) begin
          stp_data = s_q.feat ? CMD_LOCK_STATUS : CMD_READ_STATUS; // RULE14 RULE18
        end else if (s_q.feat && s_q.step != 3'h3) begin
          stp_kind = CYC_ADDR;
        end else begin
          stp_kind = CYC_READ;
          stp_last = 1'b1;
        end
      end
    endcase
    // page bits A9..A13 stay zero, block bits fill A14..A24
    if (stp_kind == CYC_ADDR) begin
      if (s_q.step == 3'h1 || s_q.step == 3'h4) begin
        stp_data = {stp_blk[BLK_LO_W-1:0], 5'h00}; // RULE24
      end else begin
        stp_data = stp_blk[BLK_W-1:BLK_LO_W]; // RULE24
      end
    end
  end

  // ----------------------------------------------------------------
  // operation sequencer
  // ----------------------------------------------------------------
  logic accept;
  logic range_bad;

  assign range_bad = (REQ_OP == OP_UNLOCK) && (REQ_START_BLK > REQ_END_BLK);
  assign accept = REQ_VALID && REQ_READY;

  always_comb begin
    s_d = s_q;
    s_d.resp_valid = 1'b0;
    s_d.err = 1'b0;
    case (s_q.st)
      S_PWRUP: begin
        // write-protect held low while the flash supply settles
        s_d.wp_n = 1'b0; // RULE23
        if (s_q.cnt == CNT_W'(PWRUP_CYC - 1)) begin
          s_d.st = S_IDLE; // RULE22
          s_d.wp_n = 1'b1;
        end else begin
          s_d.cnt = s_q.cnt + 1'b1;
        end
      end
      S_IDLE: begin
        if (accept) begin
          s_d.op = nbl_op_e'(REQ_OP);
          s_d.feat = FEATURE_EN;
          s_d.start_blk = REQ_START_BLK;
          s_d.end_blk = REQ_END_BLK;
          s_d.step = 3'h0;
          s_d.cnt = '0;
          if (range_bad) begin
            s_d.err = 1'b1; // RULE8
          end else if (REQ_OP == OP_WP_PULSE) begin
            s_d.wp_n = 1'b0;
            s_d.st = S_WPLOW;
          end else if (REQ_OP == OP_STATUS) begin
            s_d.st = S_WAITRDY;
          end else begin
            s_d.ce_n = 1'b0;
            s_d.st = S_SEND;
          end
        end
      end
      S_WAITRDY: begin
        if (READY_BUSY_N) begin
          s_d.ce_n = 1'b0; // RULE15
          s_d.st = S_SEND;
        end
      end
      S_SEND: begin
        if (cyc.done) begin
          s_d.step = s_q.step + 3'h1;
          if (stp_last) begin
            s_d.cnt = '0;
            if (stp_kind == CYC_READ) begin
              s_d.status = cyc.rdata;
              s_d.resp_valid = 1'b1;
              s_d.ce_n = 1'b1;
              s_d.st = S_IDLE;
            end else begin
              s_d.st = S_SETTLE;
            end
          end
        end
      end
      S_SETTLE: begin
        // ready/busy may take a while to drop after the last strobe
        if (s_q.cnt < CNT_W'(BUSY_SETTLE_CYC)) begin
          s_d.cnt = s_q.cnt + 1'b1;
        end else if (READY_BUSY_N) begin
          s_d.ce_n = 1'b1; // RULE20
          s_d.st = S_IDLE;
        end
      end
      S_WPLOW: begin
        if (s_q.cnt == CNT_W'(WP_PULSE_CYC - 1)) begin
          s_d.wp_n = 1'b1; // RULE4 RULE5
          s_d.st = S_IDLE;
        end else begin
          s_d.cnt = s_q.cnt + 1'b1;
        end
      end
      default: s_d.st = S_IDLE;
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      s_q <= '{st: S_PWRUP, cnt: '0, step: 3'h0, op: OP_LOCK, feat: 1'b0, start_blk: '0,
               end_blk: '0, status: 8'h00, resp_valid: 1'b0, err: 1'b0, wp_n: 1'b0, ce_n: 1'b1};
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign cyc.req = (s_q.st == S_SEND);
  assign cyc.kind = stp_kind;
  assign cyc.wdata = stp_data;

  assign REQ_READY = (s_q.st == S_IDLE);
  assign REQ_ERR = s_q.err;
  assign RESP_VALID = s_q.resp_valid;
  assign RESP_STATUS = s_q.status;
  assign LOCK_FEATURE_ENABLE_PIN = FEATURE_EN; // RULE1
  assign CE_N = s_q.ce_n;
  assign CLE = cyc.cle;
  assign ALE = cyc.ale;
  assign WE_N = cyc.we_n;
  assign READ_STROBE_N = cyc.re_n;
  assign WP_N = s_q.wp_n;
  assign IO_OUT = cyc.io_out;
  assign IO_OE = cyc.io_oe;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence seq_start_cmd;
    cyc.req && stp_kind == CYC_CMD && stp_data == CMD_UNLOCK_START && cyc.done;
  endsequence
  sequence seq_addr_pair;
    cyc.req && stp_kind == CYC_ADDR && cyc.done && (s_q.step == 3'h1 || s_q.step == 3'h4);
  endsequence

  a_unlock_order: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    seq_start_cmd |=> (s_q.step == 3'h1 && stp_kind == CYC_ADDR)) // RULE6
    else $error("unlock start command not followed by an address");
  a_addr_pair: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    seq_addr_pair |=> (cyc.req && stp_kind == CYC_ADDR)) // RULE24
    else $error("low block address byte not followed by the high byte");
  a_end_after_addr: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (cyc.req && stp_data == CMD_UNLOCK_END && stp_kind == CYC_CMD) |-> s_q.step == 3'h3) // RULE6
    else $error("unlock end command out of place");
  a_range_order: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (cyc.req && s_q.op == OP_UNLOCK) |-> s_q.start_blk <= s_q.end_blk) // RULE8
    else $error("unlock sent with start above end");
  a_range_refused: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (accept && range_bad) |=> REQ_ERR && REQ_READY ##1 !REQ_ERR) // RULE8
    else $error("bad unlock range not refused");
  a_status_not_busy: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    ($rose(cyc.req) && s_q.op == OP_STATUS) |-> $past(READY_BUSY_N)) // RULE15
    else $error("lock status read started while busy");
  a_pwrup_wait: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    $fell(s_q.st == S_PWRUP) |-> $past(s_q.cnt) == CNT_W'(PWRUP_CYC - 1)) // RULE22
    else $error("commands allowed before power-up wait ended");
  a_wp_pwrup: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (s_q.st == S_PWRUP) |-> !WP_N && !cyc.req) // RULE23
    else $error("write-protect not low during power-up");
  a_wp_pulse: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (accept && REQ_OP == OP_WP_PULSE) |=> !WP_N [*8]) // RULE4
    else $error("write-protect pulse too short");

endmodule // nbl_host

`default_nettype wire

// *** tb/nbl_flash_model.sv ***
// behavioural flash: block lock range, lock-tight, lock status and status read
// assumes host pins synchronous to clk and ready/busy pulled up outside
`timescale 1ns/10ps
`default_nettype none

module nbl_flash_model
  import nbl_pkg::*;
#(
  parameter int BUSY_CYC = 40
)(
  input wire logic clk,
  input wire logic feature_en,
  input wire logic ce_n,
  input wire logic cle,
  input wire logic ale,
  input wire logic we_n,
  input wire logic re_n,
  input wire logic wp_n,
  input wire logic [7:0] io_out,
  output logic ready_busy_n,
  output logic [7:0] io_in
);
  logic we_q = 1'b1;
  logic rng = 1'b0;
  logic tight = 1'b0;
  logic [7:0] cmd = 8'h00;
  logic [7:0] a1 = 8'h00;
  logic [7:0] last = 8'h00;
  logic [BLK_W-1:0] blk = '0;
  logic [BLK_W-1:0] lo = '0;
  logic [BLK_W-1:0] lo_p = '0;
  logic [BLK_W-1:0] hi = '0;
  int n_addr = 0;
  int busy = 0;
  int n_viol = 0;

  function automatic logic [7:0] lock_stat(input logic [BLK_W-1:0] b);
    logic inr;
    // unlock bit is also the program/erase permission of the block
    inr = rng && b >= lo && b <= hi;
    return {5'h00, inr, !tight, tight};
  endfunction

  always @(posedge clk) begin
    we_q <= we_n;
    if (busy > 0) busy <= busy - 1;
    if (!wp_n) begin
      rng <= 1'b0;
      tight <= 1'b0;
    end else if (!ce_n && !we_q && we_n && cle) begin
      cmd <= io_out;
      n_addr <= 0;
      if (busy > 0 && io_out == CMD_LOCK_STATUS) n_viol <= n_viol + 1;
      if (feature_en && !tight) begin
        if (io_out == CMD_LOCK) rng <= 1'b0;
        if (io_out == CMD_LOCK_TIGHT) tight <= 1'b1;
      end
      if (io_out == CMD_LOCK || io_out == CMD_LOCK_TIGHT) busy <= BUSY_CYC;
    end else if (!ce_n && !we_q && we_n && ale) begin
      n_addr <= n_addr + 1;
      if (n_addr == 0) begin
        a1 <= io_out;
      end else begin
        blk <= {io_out, a1[7:5]};
        // start block is only pending until the end block commits the range
        if (cmd == CMD_UNLOCK_START) lo_p <= {io_out, a1[7:5]};
        if (cmd == CMD_UNLOCK_END) begin
          busy <= BUSY_CYC;
          if (feature_en && !tight) begin
            lo <= lo_p;
            hi <= {io_out, a1[7:5]};
            rng <= 1'b1;
          end
        end
      end
    end
    if (!re_n && !ce_n) last <= io_in;
  end

  // released data lines show the inverse of the last byte, never a stale match
  always_comb begin
    ready_busy_n = (busy == 0);
    if (!re_n && !ce_n) begin
      io_in = (cmd == CMD_LOCK_STATUS) ? lock_stat(blk) : {wp_n, 1'b1, 6'h00};
    end else begin
      io_in = ~last;
    end
  end
endmodule // nbl_flash_model

`default_nettype wire

// *** tb/testbench.sv ***
// self-checking bench for the block-lock host controller
// assumes the behavioural flash model on the far side
`timescale 1ns/10ps
`default_nettype none

module testbench;
  import nbl_pkg::*;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic feature_en = 1'b1;
  logic req_valid = 1'b0;
  logic [2:0] req_op = 3'h0;
  logic [BLK_W-1:0] req_start = '0;
  logic [BLK_W-1:0] req_end = '0;
  logic req_ready, req_err, resp_valid, feat_pin, ce_n, cle, ale, we_n, re_n, wp_n, rb_n, io_oe;
  logic [7:0] resp_status;
  logic [7:0] io_in;
  logic [7:0] io_out;
  int n_errors = 0;
  int n_compared = 0;

  nbl_host i_nbl_host (.CORE_CLK(core_clk), .SYS_RST(sys_rst), .FEATURE_EN(feature_en),
    .REQ_VALID(req_valid), .REQ_OP(req_op), .REQ_START_BLK(req_start), .REQ_END_BLK(req_end),
    .REQ_READY(req_ready), .REQ_ERR(req_err), .RESP_VALID(resp_valid), .RESP_STATUS(resp_status),
    .LOCK_FEATURE_ENABLE_PIN(feat_pin), .CE_N(ce_n), .CLE(cle), .ALE(ale), .WE_N(we_n),
    .READ_STROBE_N(re_n), .WP_N(wp_n), .READY_BUSY_N(rb_n), .IO_IN(io_in), .IO_OUT(io_out),
    .IO_OE(io_oe));

  nbl_flash_model i_nbl_flash_model (.clk(core_clk), .feature_en(feat_pin), .ce_n(ce_n), .cle(cle),
    .ale(ale), .we_n(we_n), .re_n(re_n), .wp_n(wp_n), .io_out(io_out), .ready_busy_n(rb_n),
    .io_in(io_in));

  initial begin
    forever #2 core_clk = ~core_clk;
  end

  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // request held from just after an edge until the edge that takes it
  task automatic op(input logic [2:0] o, input int s, input int e);
    int k;
    @(posedge core_clk);
    #1;
    req_valid = 1'b1;
    req_op = o;
    req_start = s[BLK_W-1:0];
    req_end = e[BLK_W-1:0];
    k = 0;
    do begin @(negedge core_clk); k++; end while (req_ready !== 1'b1 && k < 2000);
    @(posedge core_clk);
    #1;
    req_valid = 1'b0;
  endtask

  task automatic finish_op();
    int k;
    k = 0;
    do begin @(negedge core_clk); k++; end while (req_ready !== 1'b1 && k < 2000);
    check("host and flash ready at completion", 8'h03, {6'h00, req_ready, rb_n});
  endtask

  task automatic t_stat(input int b, input logic [7:0] exp);
    int k;
    op(OP_STATUS, b, 0);
    k = 0;
    while (resp_valid !== 1'b1 && k < 2000) begin
      @(posedge core_clk);
      #1;
      k++;
    end
    check("status response", 8'h01, {7'h00, resp_valid});
    check("lock status", exp, resp_status);
    finish_op();
  endtask

  task automatic t_powerup();
    int k;
    bit wp_ok;
    k = 0;
    wp_ok = 1'b1;
    while (req_ready !== 1'b1 && k < 3000) begin
      @(negedge core_clk);
      if (req_ready !== 1'b1 && wp_n !== 1'b0) wp_ok = 1'b0;
      k++;
    end
    check("write protect in power-up", 8'h01, {7'h00, wp_ok});
    check("power-up wait", 8'h01, {7'h00, k >= PWRUP_CYC - 1 && k <= PWRUP_CYC + 1});
    $display("test power-up done");
  endtask

  task automatic t_ranges();
    t_stat(0, 8'h02);
    t_stat(2047, 8'h02);
    op(OP_UNLOCK, 5, 9);
    finish_op();
    t_stat(4, 8'h02);
    t_stat(5, 8'h06);
    t_stat(9, 8'h06);
    t_stat(10, 8'h02);
    op(OP_UNLOCK, 20, 20);
    finish_op();
    t_stat(20, 8'h06);
    t_stat(5, 8'h02);
    op(OP_LOCK, 0, 0);
    finish_op();
    t_stat(20, 8'h02);
    $display("test ranges done");
  endtask

  task automatic t_bad_unlock();
    int k;
    op(OP_UNLOCK, 9, 8);
    k = 0;
    repeat (3) begin
      if (req_err === 1'b1) k++;
      @(posedge core_clk);
      #1;
    end
    check("single refusal pulse", 8'h01, k[7:0]);
    check("no pins on refusal", 8'h03, {5'h00, io_oe, ce_n, we_n});
    $display("test bad unlock done");
  endtask

  task automatic t_tight();
    op(OP_UNLOCK, 3, 4);
    finish_op();
    op(OP_LOCK_TIGHT, 0, 0);
    finish_op();
    t_stat(3, 8'h05);
    t_stat(0, 8'h01);
    op(OP_UNLOCK, 0, 1);
    finish_op();
    t_stat(0, 8'h01);
    op(OP_LOCK, 0, 0);
    finish_op();
    t_stat(3, 8'h05);
    op(OP_WP_PULSE, 0, 0);
    finish_op();
    t_stat(0, 8'h02);
    t_stat(3, 8'h02);
    $display("test lock-tight done");
  endtask

  task automatic t_feature_off();
    @(posedge core_clk);
    #1;
    feature_en = 1'b0;
    #1;
    check("feature pin", 8'h00, {7'h00, feat_pin});
    t_stat(0, 8'hc0);
    @(posedge core_clk);
    #1;
    feature_en = 1'b1;
    $display("test feature off done");
  endtask

  initial begin
    repeat (16) @(posedge core_clk);
    #1;
    sys_rst = 1'b0;
    t_powerup();
    t_ranges();
    t_bad_unlock();
    t_tight();
    t_feature_off();
    check("status read while busy", 8'h00, i_nbl_flash_model.n_viol[7:0]);
    conclude();
  end

  // whole run is under 5000 cycles; eight times that means a hang
  initial begin
    #160000;
    n_errors++;
    $display("[ERR] watchdog expected finish seen hang");
    conclude();
  end
endmodule // testbench

`default_nettype wire
